// File: frame_counter_pkg.sv
// Constants for the USB host frame counter block
`default_nettype none
package frame_counter_pkg;
	localparam logic [7:0] OFS_INTERVAL = 8'h34;
	localparam logic [7:0] OFS_REMAINING = 8'h38;
	localparam logic [7:0] OFS_NUMBER = 8'h3c;
	localparam logic [7:0] OFS_CONTROL = 8'h50;
	localparam logic [7:0] OFS_SHARED_BASE = 8'h54;
	localparam logic [7:0] OFS_INT_STATUS = 8'h58;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h5c;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h60;
	localparam int INTERVAL_W = 14;
	localparam int BUDGET_W = 15;
	localparam int NUMBER_W = 16;
	localparam int TOGGLE_BIT = 31;
	localparam int BUDGET_LSB = 16;
	localparam int BUDGET_MSB = 30;
	localparam logic [13:0] INTERVAL_NOMINAL = 14'h2edf;
	localparam int CTRL_OPER_BIT = 0;
	localparam int CTRL_RESET_BIT = 1;
	localparam int INT_SOF_BIT = 0;
	localparam int INT_W = 1;
	localparam int SYS_CLK_KHZ = 250000;
	localparam int BIT_RATE_KHZ = 12000;
	// Fractional accumulator: add bit rate each cycle, tick on wrap of clock rate
	localparam logic [17:0] ACC_STEP = 18'h02ee0;
	localparam logic [17:0] ACC_WRAP = 18'h3d090;
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_REQ = 2'b01,
		WR_FLAG = 2'b11
	} wr_state_e;
endpackage
`default_nettype wire

// File: usb_host_frame_counter.sv
// Frame interval, remaining and number counters with Wishbone registers
`default_nettype none
module usb_host_frame_counter (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Shared area memory write port
	output logic mem_wr_req_out,
	output logic [31:0] mem_wr_addr_out,
	output logic [15:0] mem_wr_data_out,
	input wire logic mem_wr_ack_in,
	// Frame events and budget
	output logic sof_out,
	output logic [14:0] budget_count_out,
	// Interrupt
	output logic irq_out
);
	logic [17:0] acc_q, acc_d;
	logic tick_q, tick_d;
	logic [13:0] interval_q, interval_d;
	logic [14:0] budget_q, budget_d;
	logic itoggle_q, itoggle_d;
	logic [13:0] remain_q, remain_d;
	logic rtoggle_q, rtoggle_d;
	logic [15:0] number_q, number_d;
	logic oper_q, oper_d;
	logic [31:0] base_q, base_d;
	logic [0:0] status_q, status_d;
	logic [0:0] enable_q, enable_d;
	logic [14:0] bcount_q, bcount_d;
	logic [31:0] rdat_q, rdat_d;
	logic ack_q, ack_d;
	logic sof_q, sof_d;
	logic irq_q, irq_d;
	logic mreq_q, mreq_d;
	logic [31:0] maddr_q, maddr_d;
	logic [15:0] mdata_q, mdata_d;
	frame_counter_pkg::wr_state_e wst_q, wst_d;
	logic wr_hit, rd_hit, oper_enter, reload, boundary, flag_set;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign wr_hit = wb_cyc_in && wb_stb_in && wb_we_in && !ack_q;
	assign rd_hit = wb_cyc_in && wb_stb_in && !wb_we_in && !ack_q;

	always_comb begin
		logic [31:0] m;
		logic [31:0] ctl;
		m = 32'h0;
		ctl = 32'h0;
		// Bit-time tick at 12 MHz from 250 MHz via fractional accumulator
		if (acc_q + frame_counter_pkg::ACC_STEP >= frame_counter_pkg::ACC_WRAP) begin
			acc_d = acc_q + frame_counter_pkg::ACC_STEP - frame_counter_pkg::ACC_WRAP;
			tick_d = 1'b1;
		end else begin
			acc_d = acc_q + frame_counter_pkg::ACC_STEP;
			tick_d = 1'b0;
		end
		interval_d = interval_q;
		budget_d = budget_q;
		itoggle_d = itoggle_q;
		base_d = base_q;
		enable_d = enable_q;
		oper_d = oper_q;
		status_d = status_q;
		ack_d = 1'b0;
		rdat_d = rdat_q;
		oper_enter = 1'b0;
		if (wr_hit) begin
			ack_d = 1'b1;
			case (wb_adr_in)
				frame_counter_pkg::OFS_INTERVAL: begin
					// Reserved bits 15:14 are dropped; remaining/number writes ignored
					m = merge({itoggle_q, budget_q, 2'b00, interval_q}, wb_dat_in, wb_sel_in);
					interval_d = m[13:0];
					budget_d = m[frame_counter_pkg::BUDGET_MSB:frame_counter_pkg::BUDGET_LSB];
					itoggle_d = m[frame_counter_pkg::TOGGLE_BIT];
				end
				frame_counter_pkg::OFS_CONTROL: begin
					m = merge({30'h0, 1'b0, oper_q}, wb_dat_in, wb_sel_in);
					oper_d = m[frame_counter_pkg::CTRL_OPER_BIT];
					oper_enter = m[frame_counter_pkg::CTRL_OPER_BIT] && !oper_q;
					if (m[frame_counter_pkg::CTRL_RESET_BIT]) begin
						interval_d = frame_counter_pkg::INTERVAL_NOMINAL;
						oper_d = 1'b0;
						oper_enter = 1'b0;
					end
				end
				frame_counter_pkg::OFS_SHARED_BASE: base_d = merge(base_q, wb_dat_in, wb_sel_in);
				frame_counter_pkg::OFS_INT_CLEAR: status_d = status_q & ~wb_dat_in[0:0];
				frame_counter_pkg::OFS_INT_ENABLE: enable_d = wb_dat_in[0:0] & {1{wb_sel_in[0]}};
				default: ;
			endcase
		end else if (rd_hit) begin
			ack_d = 1'b1;
			ctl[frame_counter_pkg::CTRL_OPER_BIT] = oper_q;
			case (wb_adr_in)
				frame_counter_pkg::OFS_INTERVAL: rdat_d = {itoggle_q, budget_q, 2'b00, interval_q};
				frame_counter_pkg::OFS_REMAINING: rdat_d = {rtoggle_q, 17'h0, remain_q};
				frame_counter_pkg::OFS_NUMBER: rdat_d = {16'h0, number_q};
				frame_counter_pkg::OFS_CONTROL: rdat_d = ctl;
				frame_counter_pkg::OFS_SHARED_BASE: rdat_d = base_q;
				frame_counter_pkg::OFS_INT_STATUS: rdat_d = {31'h0, status_q};
				frame_counter_pkg::OFS_INT_ENABLE: rdat_d = {31'h0, enable_q};
				default: rdat_d = 32'h0;
			endcase
		end
		// Set wins over a same-cycle clear
		if (flag_set) begin
			status_d[frame_counter_pkg::INT_SOF_BIT] = 1'b1;
		end
		irq_d = |(status_d & enable_d);
	end

	// Frame timing
	assign reload = oper_q && tick_q && (remain_q == 14'h0);
	assign boundary = reload || oper_enter;
	always_comb begin
		remain_d = remain_q;
		rtoggle_d = rtoggle_q;
		number_d = number_q;
		bcount_d = bcount_q;
		sof_d = 1'b0;
		if (oper_enter) begin
			remain_d = interval_q;
			number_d = number_q + 16'h0001;
		end else if (reload) begin
			remain_d = interval_q;
			rtoggle_d = itoggle_q;
			number_d = number_q + 16'h0001;
		end else if (oper_q && tick_q) begin
			remain_d = remain_q - 14'h0001;
			if (bcount_q != 15'h0) begin
				bcount_d = bcount_q - 15'h0001;
			end
		end
		if (boundary) begin
			bcount_d = budget_q;
			sof_d = 1'b1;
		end
		if (!oper_d) begin
			remain_d = (oper_q && !oper_d) ? 14'h0 : remain_d;
		end
	end

	// Shared area write after SOF, then flag
	always_comb begin
		wst_d = wst_q;
		mreq_d = mreq_q;
		maddr_d = maddr_q;
		mdata_d = mdata_q;
		flag_set = 1'b0;
		case (wst_q)
			frame_counter_pkg::WR_IDLE: begin
				if (sof_q) begin
					mreq_d = 1'b1;
					maddr_d = base_q;
					mdata_d = number_q;
					wst_d = frame_counter_pkg::WR_REQ;
				end
			end
			frame_counter_pkg::WR_REQ: begin
				if (mem_wr_ack_in) begin
					mreq_d = 1'b0;
					wst_d = frame_counter_pkg::WR_FLAG;
				end
			end
			frame_counter_pkg::WR_FLAG: begin
				flag_set = 1'b1;
				wst_d = frame_counter_pkg::WR_IDLE;
			end
			default: wst_d = frame_counter_pkg::WR_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc_q <= 18'h0;
			tick_q <= 1'b0;
			interval_q <= frame_counter_pkg::INTERVAL_NOMINAL;
			budget_q <= 15'h0;
			itoggle_q <= 1'b0;
			remain_q <= 14'h0;
			rtoggle_q <= 1'b0;
			number_q <= 16'h0;
			oper_q <= 1'b0;
			base_q <= 32'h0;
			status_q <= 1'b0;
			enable_q <= 1'b0;
			bcount_q <= 15'h0;
			rdat_q <= 32'h0;
			ack_q <= 1'b0;
			sof_q <= 1'b0;
			irq_q <= 1'b0;
			mreq_q <= 1'b0;
			maddr_q <= 32'h0;
			mdata_q <= 16'h0;
			wst_q <= frame_counter_pkg::WR_IDLE;
		end else begin
			acc_q <= acc_d;
			tick_q <= tick_d;
			interval_q <= interval_d;
			budget_q <= budget_d;
			itoggle_q <= itoggle_d;
			remain_q <= remain_d;
			rtoggle_q <= rtoggle_d;
			number_q <= number_d;
			oper_q <= oper_d;
			base_q <= base_d;
			status_q <= status_d;
			enable_q <= enable_d;
			bcount_q <= bcount_d;
			rdat_q <= rdat_d;
			ack_q <= ack_d;
			sof_q <= sof_d;
			irq_q <= irq_d;
			mreq_q <= mreq_d;
			maddr_q <= maddr_d;
			mdata_q <= mdata_d;
			wst_q <= wst_d;
		end
	end

	assign wb_dat_out = rdat_q;
	assign wb_ack_out = ack_q;
	assign mem_wr_req_out = mreq_q;
	assign mem_wr_addr_out = maddr_q;
	assign mem_wr_data_out = mdata_q;
	assign sof_out = sof_q;
	assign budget_count_out = bcount_q;
	assign irq_out = irq_q;
endmodule // usb_host_frame_counter
`default_nettype wire

// File: frame_counter_checker.sv
// Port-level assertions for the frame counter block
`default_nettype none
module frame_counter_checker (
	input wire logic sys_clk_in, resetn_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out,
	input wire logic mem_wr_req_out, mem_wr_ack_in, sof_out, irq_out,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in, wb_dat_out, mem_wr_addr_out,
	input wire logic [15:0] mem_wr_data_out,
	input wire logic [14:0] budget_count_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	// Last frame number accepted by memory
	logic [15:0] num_q;
	always_ff @(posedge sys_clk_in or negedge resetn_in)
		if (!resetn_in)
			num_q <= 16'h0;
		else if (mem_wr_req_out && mem_wr_ack_in)
			num_q <= mem_wr_data_out;
	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing");
	a_req_hold: assert property (mem_wr_req_out && !mem_wr_ack_in |=>
		mem_wr_req_out && $stable(mem_wr_data_out) && $stable(mem_wr_addr_out))
		else $error("write request dropped");
	a_req_after_sof: assert property ($rose(mem_wr_req_out) |-> $past(sof_out))
		else $error("write without frame start");
	a_sof_gap: assert property (sof_out |=> !sof_out [*8])
		else $error("frame starts too close");
	a_number_step: assert property ($rose(mem_wr_req_out) |->
		mem_wr_data_out == num_q + 16'h1)
		else $error("frame number step wrong");
	a_budget_down: assert property ($changed(budget_count_out) && !sof_out &&
		!$past(sof_out) |-> budget_count_out == $past(budget_count_out) - 15'h1)
		else $error("budget count step wrong");
	a_rsvd_zero: assert property (wb_ack_out && !$past(wb_we_in) &&
		$past(wb_adr_in) == 8'h38 |-> wb_dat_out[30:14] == 17'h0)
		else $error("reserved bits set");
endmodule // frame_counter_checker
bind usb_host_frame_counter frame_counter_checker u_checker (.*);
`default_nettype wire

// File: shared_mem_model.sv
// Shared memory write acceptor with a set answer delay
`default_nettype none
module shared_mem_model #(
	parameter int ACK_DELAY = 3
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic req_in,
	input wire logic [15:0] data_in,
	output logic ack_out,
	output logic [15:0] last_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_q;
	always @(posedge clk_in or negedge resetn_in)
		if (!resetn_in) begin
			wait_q <= 0;
			ack_out <= 1'b0;
			last_out <= 16'h0;
		end else begin
			ack_out <= 1'b0;
			if (req_in && !ack_out) begin
				if (wait_q == ACK_DELAY) begin
					ack_out <= 1'b1;
					last_out <= data_in;
					wait_q <= 0;
				end else
					wait_q <= wait_q + 1;
			end
		end
endmodule // shared_mem_model
`default_nettype wire

// File: usb_host_frame_counter_test.sv
// Self-checking bench for the frame counter block
`default_nettype none
module usb_host_frame_counter_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0, resetn_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0, wb_ack_out, mem_wr_req_out, mem_wr_ack_in, sof_out, irq_out;
	logic [7:0] wb_adr_in = 8'h0;
	logic [3:0] wb_sel_in = 4'hf;
	logic [31:0] wb_dat_in = 32'h0, wb_dat_out, mem_wr_addr_out, rd, rd2;
	logic [15:0] mem_wr_data_out, mem_seen;
	logic [14:0] budget_count_out;
	int bad_count = 0, total_checks = 0, cycles = 0;
	usb_host_frame_counter u_dut (.*);
	shared_mem_model #(.ACK_DELAY(3)) u_mem (.clk_in(sys_clk_in), .resetn_in(resetn_in),
		.req_in(mem_wr_req_out), .data_in(mem_wr_data_out), .ack_out(mem_wr_ack_in),
		.last_out(mem_seen));
	always #2 sys_clk_in = ~sys_clk_in;
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e);
	endtask
	task automatic wait_irq();
		while (irq_out !== 1'b1) @(posedge sys_clk_in);
		check({31'h0, irq_out}, 32'h1);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		rd_chk(8'h34, 32'h00002edf);
		rd_chk(8'h38, 32'h0);
		rd_chk(8'h3c, 32'h0);
		bus(1'b1, 8'h38, 32'hffffffff);
		rd_chk(8'h38, 32'h0);
		rd_chk(8'h44, 32'h0);
		$display("test 1 done");
		bus(1'b1, 8'h34, 32'h81000014);
		rd_chk(8'h34, 32'h81000014);
		bus(1'b1, 8'h54, 32'h1000);
		bus(1'b1, 8'h60, 32'h1);
		bus(1'b1, 8'h50, 32'h1);
		while (mem_wr_req_out !== 1'b1) @(posedge sys_clk_in);
		check(mem_wr_addr_out, 32'h1000);
		wait_irq();
		check({16'h0, mem_seen}, 32'h1);
		rd_chk(8'h3c, 32'h1);
		bus(1'b0, 8'h38, 32'h0);
		check({31'h0, rd[13:0] <= 14'd20 && rd[13:0] != 14'h0}, 32'h1);
		rd2 = rd;
		repeat (50) @(posedge sys_clk_in);
		bus(1'b0, 8'h38, 32'h0);
		check({31'h0, rd[13:0] < rd2[13:0]}, 32'h1);
		rd_chk(8'h58, 32'h1);
		bus(1'b1, 8'h5c, 32'h1);
		rd_chk(8'h58, 32'h0);
		check({31'h0, irq_out}, 32'h0);
		$display("test 2 done");
		wait_irq();
		check({16'h0, mem_seen}, 32'h2);
		bus(1'b0, 8'h38, 32'h0);
		check({rd[31], 31'h0}, 32'h80000000);
		check({31'h0, rd[13:0] <= 14'd20}, 32'h1);
		while (sof_out !== 1'b1) @(posedge sys_clk_in);
		repeat (2) @(posedge sys_clk_in);
		check({31'h0, budget_count_out >= 15'h0fe}, 32'h1);
		// Trim the interval just after a frame start; it applies from the next one
		bus(1'b1, 8'h34, 32'h01000016);
		while (sof_out !== 1'b1) @(posedge sys_clk_in);
		bus(1'b0, 8'h38, 32'h0);
		check({rd[31], 31'h0}, 32'h0);
		check({31'h0, rd[13:0] > 14'd20 && rd[13:0] <= 14'd22}, 32'h1);
		bus(1'b1, 8'h60, 32'h0);
		check({31'h0, irq_out}, 32'h0);
		$display("test 3 done");
		bus(1'b1, 8'h50, 32'h2);
		bus(1'b0, 8'h34, 32'h0);
		check({18'h0, rd[13:0]}, 32'h2edf);
		bus(1'b1, 8'h34, 32'h01000014);
		rd_chk(8'h34, 32'h01000014);
		$display("test 4 done");
		close_out();
	end
endmodule // usb_host_frame_counter_test
`default_nettype wire
